//--- core/i2m_pkg.sv
// constants, types and reset state of the two-wire bus master
// assumes one 125 MHz system clock and a plain register port
package i2m_pkg;

	// register offsets as printed; the port compares them directly
	localparam logic [15:0] ADR_RCV = 16'h0200;
	localparam logic [15:0] ADR_TRN = 16'h0202;
	localparam logic [15:0] ADR_BRG = 16'h0204;
	localparam logic [15:0] ADR_CON = 16'h0206;
	localparam logic [15:0] ADR_STA = 16'h0208;
	localparam logic [15:0] ADR_ADD = 16'h020A;

	localparam logic [7:0] RST_TRN = 8'hFF;
	localparam logic [15:0] RST_CON = 16'h1000;
	localparam logic [15:0] CON_MSK = 16'hBFFF;
	localparam logic [15:0] CON_WMSK = 16'hBFE0;
	localparam logic [15:0] REQ_MSK = 16'h001F;
	localparam logic [15:0] STA_MSK = 16'hC7FF;

	// control bits
	localparam int C_EN = 15;
	localparam int C_SIDL = 13;
	localparam int C_ACKDT = 5;
	localparam int C_ACKEN = 4;
	localparam int C_RXEN = 3;
	localparam int C_PEN = 2;
	localparam int C_RSEN = 1;
	localparam int C_SEN = 0;

	// status bits
	localparam int S_ACKST = 15;
	localparam int S_TRST = 14;
	localparam int S_BCL = 10;
	localparam int S_IWCOL = 7;
	localparam int S_P = 4;
	localparam int S_S = 3;
	localparam int S_RBF = 1;
	localparam int S_TBF = 0;

	// rates; one baud count lasts BRG_PRE system cycles
	localparam int CLK_HZ = 125_000_000;
	localparam int SCL_STD_HZ = 100_000;
	localparam int SCL_FAST_HZ = 400_000;
	localparam int SCL_MAX_HZ = 1_000_000;
	localparam int BRG_PRE = 2;
	localparam int RELOAD_MAX_RATE = CLK_HZ / (2 * SCL_MAX_HZ * BRG_PRE) - 1;
	localparam int RELOAD_STD_RATE = CLK_HZ / (2 * SCL_STD_HZ * BRG_PRE) - 1;
	localparam logic [0:0] PRE_TOP = 1'(BRG_PRE - 1);

	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [1:0] STEP_0 = 2'h0;
	localparam logic [1:0] STEP_1 = 2'h1;
	localparam logic [1:0] STEP_2 = 2'h2;

	typedef enum logic [2:0] {
		M_IDLE = 3'b000,
		M_START = 3'b001,
		M_RSTART = 3'b010,
		M_STOP = 3'b011,
		M_TX = 3'b100,
		M_RX = 3'b101,
		M_ACK = 3'b110
	} i2m_mode_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} i2m_bus_t;

	typedef struct packed {
		logic scl_out;
		logic scl_oe_n;
		logic sda_out;
		logic sda_oe_n;
	} i2m_pins_t;

	typedef struct packed {
		logic [7:0] rcv;
		logic [7:0] trn;
		logic [8:0] baud_generator;
		logic [15:0] con;
		logic [15:0] sta;
		logic [9:0] add;
		i2m_mode_t mode;
		logic [1:0] step;
		logic [3:0] bitn;
		logic [7:0] shf;
		logic [8:0] cnt;
		logic [0:0] pre;
		logic wait_hi;
		logic lost;
		logic scl_rel;
		logic sda_rel;
		logic [1:0] scl_sy;
		logic [1:0] sda_sy;
		logic sda_prv;
		logic mif;
		logic [15:0] rdata;
	} i2m_state_t;

	localparam i2m_state_t ST_RST = '{
		trn: RST_TRN,
		con: RST_CON,
		mode: M_IDLE,
		scl_rel: 1'b1,
		sda_rel: 1'b1,
		scl_sy: 2'h3,
		sda_sy: 2'h3,
		sda_prv: 1'b1,
		default: '0
	};

endpackage

//--- core/i2m_master.sv
// two-wire bus master: start/stop, byte send and receive, baud counter
// assumes open-drain pads resolved outside, register port on clk_sys
//
// What this block does
// - receive starts only if set while idle
// - clock toggles per rollover, received data shifted in on rise, sent data on the low-going rollover
// - baud counter reloads, counts to zero, reloads on the rollover at zero
// - rates from 100 kHz up to 1 MHz
// - released clock pauses counter until seen high
// - lost one-bit flags collision, pulses flag, idles
// - collision halts send, clears buffer-full, releases lines
// - collision aborts conditions, clears request bits
// - after collision, bus stop pulses flag
// - new send always begins at first bit
// - sleep aborts any transfer in progress
// - cpu idle halts only with stop-in-idle set
// - unimplemented bits read as zero
// - send write sets buffer-full and starts counting
// - flag pulses after each completed master event
// - master makes clock, start and stop
// - acknowledge bit driven after received byte
//
// The strobed register port was decided locally.
`timescale 1ns/10ps

module i2m_master (
	input wire logic clk_sys,
	input wire logic rst,
	input wire i2m_pkg::i2m_bus_t bus,
	output logic [15:0] rd_data,
	input wire logic scl_in,
	input wire logic sda_in,
	output i2m_pkg::i2m_pins_t pins,
	output logic mif,
	input wire logic sleep_req,
	input wire logic cpu_idle
);

	// ************************************************************
	// state and derived terms
	// ************************************************************
	i2m_pkg::i2m_state_t st_reg;
	i2m_pkg::i2m_state_t st_next;
	logic scl_h;
	logic sda_h;
	logic halt;
	logic run;
	logic idle;
	logic rise;
	logic tick;
	logic chk;
	logic coll;

	function automatic logic is_wr(input i2m_pkg::i2m_bus_t b,
		input logic [15:0] a);
		is_wr = b.wr && (b.addr == a);
	endfunction

	assign scl_h = st_reg.scl_sy[1];
	assign sda_h = st_reg.sda_sy[1];
	assign halt = cpu_idle && st_reg.con[i2m_pkg::C_SIDL];
	assign run = st_reg.con[i2m_pkg::C_EN] && !halt &&
		(st_reg.mode != i2m_pkg::M_IDLE);
	assign idle = st_reg.con[i2m_pkg::C_EN] &&
		(st_reg.mode == i2m_pkg::M_IDLE) &&
		((st_reg.con & i2m_pkg::REQ_MSK) == 16'h0000) &&
		!st_reg.sta[i2m_pkg::S_TBF];
	// released clock seen high: reload point and data sample point
	assign rise = run && st_reg.wait_hi && scl_h;
	assign tick = run && !st_reg.wait_hi &&
		(st_reg.pre == i2m_pkg::PRE_TOP) && (st_reg.cnt == 9'h000);
	assign chk = (st_reg.mode == i2m_pkg::M_START) ||
		(st_reg.mode == i2m_pkg::M_RSTART) ||
		(st_reg.mode == i2m_pkg::M_STOP) ||
		(st_reg.mode == i2m_pkg::M_ACK) ||
		((st_reg.mode == i2m_pkg::M_TX) &&
		(st_reg.bitn != i2m_pkg::BIT_ACK));
	assign coll = tick && chk && scl_h && st_reg.sda_rel && !sda_h;

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		st_next = st_reg;
		st_next.mif = 1'b0;
		st_next.rdata = 16'h0000;
		st_next.scl_sy = {st_reg.scl_sy[0], scl_in};
		st_next.sda_sy = {st_reg.sda_sy[0], sda_in};
		st_next.sda_prv = sda_h;

		// bus monitor: start and stop seen from any master
		if (scl_h && st_reg.sda_prv && !sda_h) begin
			st_next.sta[i2m_pkg::S_S] = 1'b1;
			st_next.sta[i2m_pkg::S_P] = 1'b0;
		end
		if (scl_h && !st_reg.sda_prv && sda_h) begin
			st_next.sta[i2m_pkg::S_P] = 1'b1;
			st_next.sta[i2m_pkg::S_S] = 1'b0;
			if (st_reg.lost) begin
				st_next.lost = 1'b0;
				st_next.mif = 1'b1;
			end
		end

		// register reads; reading the receive buffer empties it
		if (bus.rd) begin
			case (bus.addr)
			i2m_pkg::ADR_RCV: begin
				st_next.rdata = {8'h00, st_reg.rcv};
				st_next.sta[i2m_pkg::S_RBF] = 1'b0;
			end
			i2m_pkg::ADR_TRN: st_next.rdata = {8'h00, st_reg.trn};
			i2m_pkg::ADR_BRG: st_next.rdata = {7'h00, st_reg.baud_generator};
			i2m_pkg::ADR_CON: st_next.rdata = st_reg.con & i2m_pkg::CON_MSK;
			i2m_pkg::ADR_STA: st_next.rdata = st_reg.sta & i2m_pkg::STA_MSK;
			i2m_pkg::ADR_ADD: st_next.rdata = {6'h00, st_reg.add};
			default: st_next.rdata = 16'h0000;
			endcase
		end

		// register writes
		if (is_wr(bus, i2m_pkg::ADR_TRN)) begin
			if (idle) begin
				st_next.trn = bus.wdata[7:0];
				st_next.shf = bus.wdata[7:0];
				st_next.sta[i2m_pkg::S_TBF] = 1'b1;
				st_next.sta[i2m_pkg::S_TRST] = 1'b1;
				st_next.mode = i2m_pkg::M_TX;
				st_next.bitn = 4'h0;
				st_next.sda_rel = bus.wdata[7];
				st_next.cnt = st_reg.baud_generator;
			end else begin
				st_next.sta[i2m_pkg::S_IWCOL] = 1'b1;
			end
		end
		if (is_wr(bus, i2m_pkg::ADR_BRG)) begin
			st_next.baud_generator = bus.wdata[8:0];
		end
		if (is_wr(bus, i2m_pkg::ADR_ADD)) begin
			st_next.add = bus.wdata[9:0];
		end
		if (is_wr(bus, i2m_pkg::ADR_STA)) begin
			st_next.sta[i2m_pkg::S_BCL] = st_reg.sta[i2m_pkg::S_BCL] &
				bus.wdata[i2m_pkg::S_BCL];
			st_next.sta[i2m_pkg::S_IWCOL] = st_reg.sta[i2m_pkg::S_IWCOL] &
				bus.wdata[i2m_pkg::S_IWCOL];
		end
		if (is_wr(bus, i2m_pkg::ADR_CON)) begin
			st_next.con = (bus.wdata & i2m_pkg::CON_WMSK) |
				(st_reg.con & i2m_pkg::REQ_MSK);
			// one request taken at a time, only when idle
			if (idle) begin
				st_next.cnt = st_reg.baud_generator;
				st_next.step = i2m_pkg::STEP_0;
				if (bus.wdata[i2m_pkg::C_SEN]) begin
					st_next.con[i2m_pkg::C_SEN] = 1'b1;
					st_next.mode = i2m_pkg::M_START;
					st_next.sda_rel = 1'b1;
					st_next.scl_rel = 1'b1;
					st_next.wait_hi = 1'b1;
				end else if (bus.wdata[i2m_pkg::C_RSEN]) begin
					st_next.con[i2m_pkg::C_RSEN] = 1'b1;
					st_next.mode = i2m_pkg::M_RSTART;
					st_next.sda_rel = 1'b1;
				end else if (bus.wdata[i2m_pkg::C_PEN]) begin
					st_next.con[i2m_pkg::C_PEN] = 1'b1;
					st_next.mode = i2m_pkg::M_STOP;
					st_next.sda_rel = 1'b0;
				end else if (bus.wdata[i2m_pkg::C_RXEN]) begin
					st_next.con[i2m_pkg::C_RXEN] = 1'b1;
					st_next.mode = i2m_pkg::M_RX;
					st_next.sda_rel = 1'b1;
					st_next.bitn = 4'h0;
				end else if (bus.wdata[i2m_pkg::C_ACKEN]) begin
					st_next.con[i2m_pkg::C_ACKEN] = 1'b1;
					st_next.mode = i2m_pkg::M_ACK;
					st_next.sda_rel = bus.wdata[i2m_pkg::C_ACKDT];
				end
			end
		end

		// ************************************************************
		// baud counter
		// ************************************************************
		if (run) begin
			st_next.pre = ~st_reg.pre;
		end
		if (rise) begin
			st_next.wait_hi = 1'b0;
			st_next.cnt = st_reg.baud_generator;
			if (st_reg.mode == i2m_pkg::M_RX) begin
				st_next.shf = {st_reg.shf[6:0], sda_h};
			end
			if ((st_reg.mode == i2m_pkg::M_TX) &&
				(st_reg.bitn == i2m_pkg::BIT_ACK)) begin
				st_next.sta[i2m_pkg::S_ACKST] = sda_h;
			end
		end
		if (run && !st_reg.wait_hi && (st_reg.pre == i2m_pkg::PRE_TOP) &&
			(st_reg.cnt != 9'h000)) begin
			st_next.cnt = st_reg.cnt - 9'h001;
		end

		// ************************************************************
		// sequencer, acting on each rollover
		// ************************************************************
		if (coll) begin
			st_next.sta[i2m_pkg::S_BCL] = 1'b1;
			st_next.mif = 1'b1;
			st_next.lost = 1'b1;
			st_next.mode = i2m_pkg::M_IDLE;
			st_next.step = i2m_pkg::STEP_0;
			st_next.scl_rel = 1'b1;
			st_next.sda_rel = 1'b1;
			st_next.wait_hi = 1'b0;
			st_next.sta[i2m_pkg::S_TBF] = 1'b0;
			st_next.sta[i2m_pkg::S_TRST] = 1'b0;
			st_next.con = st_reg.con & ~i2m_pkg::REQ_MSK;
		end else if (tick) begin
			st_next.cnt = st_reg.baud_generator;
			case (st_reg.mode)
			i2m_pkg::M_START: begin
				if (st_reg.step == i2m_pkg::STEP_0) begin
					st_next.sda_rel = 1'b0;
					st_next.step = i2m_pkg::STEP_1;
				end else begin
					st_next.scl_rel = 1'b0;
					st_next.con[i2m_pkg::C_SEN] = 1'b0;
					st_next.mode = i2m_pkg::M_IDLE;
					st_next.mif = 1'b1;
				end
			end
			i2m_pkg::M_RSTART: begin
				if (st_reg.step == i2m_pkg::STEP_0) begin
					st_next.scl_rel = 1'b1;
					st_next.wait_hi = 1'b1;
					st_next.step = i2m_pkg::STEP_1;
				end else if (st_reg.step == i2m_pkg::STEP_1) begin
					st_next.sda_rel = 1'b0;
					st_next.step = i2m_pkg::STEP_2;
				end else begin
					st_next.scl_rel = 1'b0;
					st_next.con[i2m_pkg::C_RSEN] = 1'b0;
					st_next.mode = i2m_pkg::M_IDLE;
					st_next.mif = 1'b1;
				end
			end
			i2m_pkg::M_STOP: begin
				if (st_reg.step == i2m_pkg::STEP_0) begin
					st_next.scl_rel = 1'b1;
					st_next.wait_hi = 1'b1;
					st_next.step = i2m_pkg::STEP_1;
				end else if (st_reg.step == i2m_pkg::STEP_1) begin
					st_next.sda_rel = 1'b1;
					st_next.step = i2m_pkg::STEP_2;
				end else begin
					st_next.con[i2m_pkg::C_PEN] = 1'b0;
					st_next.mode = i2m_pkg::M_IDLE;
					st_next.mif = 1'b1;
				end
			end
			default: begin
				if (!st_reg.scl_rel) begin
					st_next.scl_rel = 1'b1;
					st_next.wait_hi = 1'b1;
				end else begin
					st_next.scl_rel = 1'b0;
					case (st_reg.mode)
					i2m_pkg::M_TX: begin
						if (st_reg.bitn == i2m_pkg::BIT_ACK) begin
							st_next.sta[i2m_pkg::S_TBF] = 1'b0;
							st_next.sta[i2m_pkg::S_TRST] = 1'b0;
							st_next.mode = i2m_pkg::M_IDLE;
							st_next.mif = 1'b1;
						end else begin
							st_next.bitn = st_reg.bitn + 4'h1;
							st_next.shf = {st_reg.shf[6:0], 1'b0};
							st_next.sda_rel = (st_reg.bitn == i2m_pkg::BIT_LAST) ?
								1'b1 : st_reg.shf[6];
						end
					end
					i2m_pkg::M_RX: begin
						if (st_reg.bitn == i2m_pkg::BIT_LAST) begin
							st_next.rcv = st_reg.shf;
							st_next.sta[i2m_pkg::S_RBF] = 1'b1;
							st_next.con[i2m_pkg::C_RXEN] = 1'b0;
							st_next.mode = i2m_pkg::M_IDLE;
							st_next.mif = 1'b1;
						end else begin
							st_next.bitn = st_reg.bitn + 4'h1;
						end
					end
					default: begin
						st_next.con[i2m_pkg::C_ACKEN] = 1'b0;
						st_next.sda_rel = 1'b1;
						st_next.mode = i2m_pkg::M_IDLE;
						st_next.mif = 1'b1;
					end
					endcase
				end
			end
			endcase
		end

		// sleep or disable: abort and let go of the bus
		if (sleep_req || !st_reg.con[i2m_pkg::C_EN]) begin
			st_next.mode = i2m_pkg::M_IDLE;
			st_next.step = i2m_pkg::STEP_0;
			st_next.scl_rel = 1'b1;
			st_next.sda_rel = 1'b1;
			st_next.wait_hi = 1'b0;
			st_next.con = st_next.con & ~i2m_pkg::REQ_MSK;
			st_next.sta[i2m_pkg::S_TBF] = 1'b0;
			st_next.sta[i2m_pkg::S_TRST] = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_reg <= i2m_pkg::ST_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rd_data = st_reg.rdata;
	assign mif = st_reg.mif;
	assign pins = '{scl_out: 1'b0, scl_oe_n: st_reg.scl_rel,
		sda_out: 1'b0, sda_oe_n: st_reg.sda_rel};

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_coll;
		coll && !sleep_req;
	endsequence
	sequence s_released;
		pins.scl_oe_n && pins.sda_oe_n;
	endsequence

	property p_rx_ignore;
		is_wr(bus, i2m_pkg::ADR_CON) && bus.wdata[i2m_pkg::C_RXEN] &&
		!idle && !st_reg.con[i2m_pkg::C_RXEN] |=>
		!st_reg.con[i2m_pkg::C_RXEN];
	endproperty
	a_rx_ignore: assert property (p_rx_ignore)
		else $error("receive enable taken while busy");

	property p_rx_shift;
		rise && (st_reg.mode == i2m_pkg::M_RX) |=>
		st_reg.shf[0] == $past(sda_h);
	endproperty
	a_rx_shift: assert property (p_rx_shift)
		else $error("received bit not shifted in");

	property p_brg_down;
		run && !st_reg.wait_hi && (st_reg.pre == i2m_pkg::PRE_TOP) &&
		(st_reg.cnt != 9'h000) && !sleep_req |=>
		st_reg.cnt == $past(st_reg.cnt) - 9'h001;
	endproperty
	a_brg_down: assert property (p_brg_down)
		else $error("baud counter did not count down");

	property p_wait_hold;
		st_reg.wait_hi && !scl_h |=> $stable(st_reg.cnt);
	endproperty
	a_wait_hold: assert property (p_wait_hold)
		else $error("baud counter ran while clock held low");

	property p_reload;
		rise |=> (st_reg.cnt == $past(st_reg.baud_generator)) && !st_reg.wait_hi;
	endproperty
	a_reload: assert property (p_reload)
		else $error("no reload when clock seen high");

	property p_coll;
		s_coll |=> (st_reg.mode == i2m_pkg::M_IDLE) && mif &&
		st_reg.sta[i2m_pkg::S_BCL] ##0 s_released;
	endproperty
	a_coll: assert property (p_coll)
		else $error("collision not handled");

	property p_coll_tbf;
		s_coll |=> !st_reg.sta[i2m_pkg::S_TBF] && !st_reg.sta[i2m_pkg::S_TRST];
	endproperty
	a_coll_tbf: assert property (p_coll_tbf)
		else $error("buffer full kept after collision");

	property p_coll_req;
		coll |=> (st_reg.con & i2m_pkg::REQ_MSK) == 16'h0000;
	endproperty
	a_coll_req: assert property (p_coll_req)
		else $error("request bits kept after collision");

	property p_stop_flag;
		st_reg.lost && scl_h && !st_reg.sda_prv && sda_h |=>
		mif && !st_reg.lost;
	endproperty
	a_stop_flag: assert property (p_stop_flag)
		else $error("stop after collision not flagged");

	property p_tx_first;
		is_wr(bus, i2m_pkg::ADR_TRN) && idle && !sleep_req |=>
		st_reg.sta[i2m_pkg::S_TBF] && (st_reg.bitn == 4'h0) &&
		(pins.sda_oe_n == $past(bus.wdata[7]));
	endproperty
	a_tx_first: assert property (p_tx_first)
		else $error("send did not begin at first bit");

	property p_sleep;
		sleep_req |=> (st_reg.mode == i2m_pkg::M_IDLE) ##0 s_released;
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("transfer not aborted by sleep");

	property p_halt;
		halt && !sleep_req && (st_reg.mode != i2m_pkg::M_IDLE) |=>
		$stable(st_reg.cnt) && $stable(st_reg.mode);
	endproperty
	a_halt: assert property (p_halt)
		else $error("block ran while halted in idle");

	property p_unimpl;
		bus.rd && (bus.addr == i2m_pkg::ADR_TRN) |=> rd_data[15:8] == 8'h00;
	endproperty
	a_unimpl: assert property (p_unimpl)
		else $error("unimplemented bits not zero");

	property p_ack;
		st_reg.mode == i2m_pkg::M_ACK |->
		pins.sda_oe_n == st_reg.con[i2m_pkg::C_ACKDT];
	endproperty
	a_ack: assert property (p_ack)
		else $error("acknowledge level wrong");

endmodule

//--- tb/i2m_far_model.sv
// far side of the bus: a slave that sends bytes, stretches SCL, grabs SDA
// assumes resolved open-drain lines, sampled on clk_sys
`timescale 1ns/10ps

module i2m_far_model (
	input wire logic clk_sys,
	input wire logic scl,
	input wire logic send,
	input wire logic [7:0] tx_byte,
	input wire logic grab,
	input wire logic [7:0] stretch,
	output logic scl_oe_n,
	output logic sda_oe_n
);
	logic [7:0] shf = 8'h00;
	logic [3:0] left = 4'h0;
	logic [7:0] hold = 8'h00;
	logic scl_q = 1'b1;
	logic send_q = 1'b0;

	// ********************************
	// byte sender, msb first
	// ********************************
	always @(posedge clk_sys) begin
		scl_q <= scl;
		send_q <= send;
		if (hold != 8'h00)
			hold <= hold - 8'h01;
		if (!send)
			left <= 4'h0;
		else if (!send_q) begin
			shf <= tx_byte;
			left <= 4'h8;
		end else if (scl_q && !scl && left != 4'h0) begin
			shf <= {shf[6:0], 1'b0};
			left <= left - 4'h1;
			hold <= stretch;
		end
	end
	// released lines float to the pull-up level
	assign sda_oe_n = !grab && !(left != 4'h0 && !shf[7]);
	assign scl_oe_n = (hold == 8'h00);
endmodule

//--- tb/testbench.sv
// self-checking bench of the two-wire bus master
// assumes i2m_pkg, i2m_master and i2m_far_model compiled first
`timescale 1ns/10ps

`define CHECK_EQ(nm, ex, got) begin \
	n_tests++; \
	if ((got) !== (ex)) begin \
		mismatches++; \
		$display("wrong value %s exp %h got %h", nm, ex, got); \
	end \
end

module testbench;
	localparam logic [15:0] A_RX = i2m_pkg::ADR_RCV;
	localparam logic [15:0] A_TX = i2m_pkg::ADR_TRN;
	localparam logic [15:0] A_BAUD = i2m_pkg::ADR_BRG;
	localparam logic [15:0] A_CTL = i2m_pkg::ADR_CON;
	localparam logic [15:0] A_ST = i2m_pkg::ADR_STA;
	localparam logic [15:0] A_OWN = i2m_pkg::ADR_ADD;
	localparam logic [15:0] ALL = 16'hFFFF;
	localparam logic [15:0] RLD = 16'(i2m_pkg::RELOAD_MAX_RATE);
	localparam logic [15:0] MIN_HI =
		16'(i2m_pkg::RELOAD_MAX_RATE * i2m_pkg::BRG_PRE);
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	i2m_pkg::i2m_bus_t bus = '0;
	logic [15:0] rd_data;
	i2m_pkg::i2m_pins_t pins;
	i2m_pkg::i2m_pins_t snap;
	logic mif;
	logic sleep_req = 1'b0;
	logic cpu_idle = 1'b0;
	logic send = 1'b0;
	logic grab = 1'b0;
	logic [7:0] stretch = 8'h00;
	logic [7:0] tx_byte = 8'h00;
	logic [7:0] b1;
	logic scl_oe_n_f, sda_oe_n_f, scl_w, sda_w;
	logic scl_p = 1'b1;
	logic rd_q = 1'b0;
	logic hi_chk = 1'b0;
	logic ack_mon = 1'b0;
	logic ack_seen = 1'b0;
	logic [8:0] cap = 9'h000;
	logic [15:0] hi_cnt = 16'h0000;
	logic [15:0] hi_min = 16'hFFFF;
	logic [15:0] e_v, m_v;
	logic [15:0] exp_q[$];
	logic [15:0] msk_q[$];
	int mismatches = 0;
	int n_tests = 0;
	int mif_cnt = 0;
	int cyc = 0;
	int seed = 54;

	always #4 clk_sys = !clk_sys;
	assign scl_w = pins.scl_oe_n & scl_oe_n_f;
	assign sda_w = pins.sda_oe_n & sda_oe_n_f;

	i2m_master dut_u (.clk_sys(clk_sys), .rst(rst), .bus(bus),
		.rd_data(rd_data), .scl_in(scl_w), .sda_in(sda_w), .pins(pins),
		.mif(mif), .sleep_req(sleep_req), .cpu_idle(cpu_idle));
	i2m_far_model far_u (.clk_sys(clk_sys), .scl(scl_w), .send(send),
		.tx_byte(tx_byte), .grab(grab), .stretch(stretch),
		.scl_oe_n(scl_oe_n_f), .sda_oe_n(sda_oe_n_f));

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ********************************
	// output watcher
	// ********************************
	always @(posedge clk_sys) begin
		rd_q <= bus.rd;
		scl_p <= scl_w;
		cyc <= cyc + 1;
		hi_cnt <= scl_w ? hi_cnt + 16'h0001 : 16'h0000;
		if (mif === 1'b1)
			mif_cnt <= mif_cnt + 1;
		if (rd_q && exp_q.size() > 0) begin
			e_v = exp_q.pop_front();
			m_v = msk_q.pop_front();
			`CHECK_EQ("rd_data", e_v, rd_data & m_v)
		end
		if (scl_p && !scl_w && hi_chk && hi_cnt < hi_min)
			hi_min <= hi_cnt;
		if (!scl_p && scl_w)
			cap <= {cap[7:0], sda_w};
		if (ack_mon && scl_w && pins.sda_oe_n === 1'b0)
			ack_seen <= 1'b1;
		if (cyc == 40000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	// ********************************
	// register port tasks
	// ********************************
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clk_sys);
		bus.wr <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [15:0] e,
		input logic [15:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		@(posedge clk_sys);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk_sys);
		bus.rd <= 1'b0;
	endtask

	task automatic wait_mif;
		int n;
		n = mif_cnt;
		repeat (20000) begin
			@(posedge clk_sys);
			if (mif_cnt != n)
				return;
		end
		mismatches++;
		$display("wrong value mif exp 1 got 0");
	endtask

	task automatic start_bus;
		wr(A_CTL, 16'h8001);
		wait_mif();
	endtask

	// ********************************
	// main sequence
	// ********************************
	initial begin
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		rd(A_RX, 16'h0000, ALL);
		rd(A_TX, 16'h00FF, ALL);
		rd(A_BAUD, 16'h0000, ALL);
		rd(A_CTL, 16'h1000, ALL);
		rd(A_ST, 16'h0000, ALL);
		rd(A_OWN, 16'h0000, ALL);
		wr(16'h020E, ALL);
		rd(16'h020C, 16'h0000, ALL);
		wr(A_BAUD, ALL);
		wr(A_OWN, ALL);
		rd(A_BAUD, 16'h01FF, ALL);
		rd(A_OWN, 16'h03FF, ALL);
		wr(A_BAUD, RLD);
		wr(A_CTL, 16'h8000);
		rd(A_ST, 16'h0000, 16'h0018);
		start_bus();
		rd(A_ST, 16'h0008, 16'h0018);
		// receive while cpu idles with stop-in-idle clear
		b1 = 8'($random(seed));
		tx_byte <= b1;
		send <= 1'b1;
		cpu_idle <= 1'b1;
		hi_chk <= 1'b1;
		wr(A_CTL, 16'h8008);
		wait_mif();
		cpu_idle <= 1'b0;
		send <= 1'b0;
		`CHECK_EQ("rx wire", b1, cap[7:0])
		rd(A_ST, 16'h0002, 16'h0002);
		rd(A_RX, {8'h00, b1}, ALL);
		rd(A_CTL, 16'h8000, ALL);
		ack_mon <= 1'b1;
		wr(A_CTL, 16'h8010);
		wait_mif();
		ack_mon <= 1'b0;
		`CHECK_EQ("ack low", 1'b1, ack_seen)
		rd(A_CTL, 16'h8000, ALL);
		// stretched receive, refused requests, halt in idle
		b1 = 8'($random(seed));
		tx_byte <= b1;
		stretch <= 8'hC8;
		send <= 1'b1;
		wr(A_CTL, 16'h8008);
		wr(A_CTL, 16'hA00C);
		repeat (100) @(posedge clk_sys);
		cpu_idle <= 1'b1;
		repeat (2) @(posedge clk_sys);
		snap = pins;
		repeat (100) @(posedge clk_sys);
		`CHECK_EQ("halted pins", snap, pins)
		cpu_idle <= 1'b0;
		wr(A_CTL, 16'h8000);
		wait_mif();
		hi_chk <= 1'b0;
		send <= 1'b0;
		stretch <= 8'h00;
		rd(A_RX, {8'h00, b1}, ALL);
		`CHECK_EQ("scl high time", 1'b1, hi_min >= MIN_HI)
		rd(A_CTL, 16'h8000, ALL);
		wr(A_CTL, 16'h8004);
		wait_mif();
		rd(A_ST, 16'h0010, 16'h0018);
		// collision in a byte send
		start_bus();
		wr(A_TX, 16'h00FF);
		grab <= 1'b1;
		wait_mif();
		`CHECK_EQ("released", 2'h3, {pins.scl_oe_n, pins.sda_oe_n})
		rd(A_ST, 16'h0400, 16'h4401);
		grab <= 1'b0;
		wait_mif();
		wr(A_ST, 16'h0000);
		rd(A_ST, 16'h0010, 16'h0410);
		// fresh byte after collision, receive request refused while sending
		start_bus();
		wr(A_TX, 16'h00A5);
		rd(A_ST, 16'h0001, 16'h0001);
		wr(A_CTL, 16'h8008);
		rd(A_CTL, 16'h8000, ALL);
		wait_mif();
		`CHECK_EQ("tx wire", 8'hA5, cap[8:1])
		rd(A_ST, 16'h0000, 16'h0001);
		// repeated start while the bus is still held
		wr(A_CTL, 16'h8002);
		wait_mif();
		rd(A_ST, 16'h0008, 16'h0018);
		rd(A_CTL, 16'h8000, ALL);
		grab <= 1'b1;
		wr(A_CTL, 16'h8004);
		wait_mif();
		rd(A_CTL, 16'h8000, ALL);
		rd(A_ST, 16'h0400, 16'h0400);
		grab <= 1'b0;
		wait_mif();
		// sleep in mid-receive
		start_bus();
		tx_byte <= 8'($random(seed));
		send <= 1'b1;
		wr(A_CTL, 16'h8008);
		repeat (150) @(posedge clk_sys);
		sleep_req <= 1'b1;
		repeat (3) @(posedge clk_sys);
		sleep_req <= 1'b0;
		`CHECK_EQ("sleep pins", 2'h3, {pins.scl_oe_n, pins.sda_oe_n})
		rd(A_CTL, 16'h8000, ALL);
		send <= 1'b0;
		repeat (4) @(posedge clk_sys);
		tally_and_finish();
	end
endmodule
